// file: hdl/tcsp_pkg.sv
// constants, field layouts and state type for the codec time-slot serial port
// Contract
// - frame is 256 bit clocks, sixteen slots
// - two control slots, eight sample slots, six idle
// - active-high frame sync restarts slot count
// - msb first, launch rising, sample falling
// - master drives bit clock and frame sync
// - control slots honoured only while select low
// - eight sample slots follow control slots
// - command bit 15: one write, zero read
// - command bits 14/13 must match address pins
// - read reply in slot 1 top byte
// - register number zero changes nothing
// - interval N: control every N+1 frames
// - interval register resets to zero
// - first gap after write is N-1 frames
// - sample word is one slot, three formats
// - coding chosen by coding register bits 7:6
// - flag register bit enables valid flag
// - flag on: linear msb bit 14, companded bit 7
// - flag in bit 15, companded code bits 7:0
// - codec slots 2+2*addr and next one
package tcsp_pkg;

   // ****************************************
   // timing
   // ****************************************
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned BCLK_HZ = 2_048_000;
   // half bit-clock period in system cycles, rounded down so the rate is never slow
   localparam logic [3:0] BCLK_HALF_CYC = 4'(CLK_HZ / (2 * BCLK_HZ));

   // ****************************************
   // frame and command word layout
   // ****************************************
   localparam logic [3:0] SLOT_CMD = 4'h0;
   localparam logic [3:0] SLOT_DATA = 4'h1;
   localparam logic [3:0] SLOT_SAMPLE_BASE = 4'h2;
   localparam int unsigned CMD_RW_BIT = 15;
   localparam int unsigned CMD_ADH_BIT = 14;
   localparam int unsigned CMD_ADL_BIT = 13;
   localparam int unsigned CMD_REG_HI = 12;
   localparam int unsigned CMD_REG_LO = 5;
   localparam int unsigned NREGS = 32;
   localparam logic [7:0] REG_FLAG = 8'h0D;
   localparam logic [7:0] REG_CODING = 8'h0F;
   localparam logic [7:0] REG_INTERVAL = 8'h11;
   localparam int unsigned FLAG_EN_BIT = 0;
   localparam int unsigned CODING_HI = 7;
   localparam int unsigned CODING_LO = 6;

   typedef enum logic [1:0] {
      CODE_LIN = 2'b00,
      CODE_MU = 2'b01,
      CODE_A = 2'b10
   } tcsp_coding_e;

   // ****************************************
   // pin synchroniser lanes
   // ****************************************
   localparam int unsigned SY_BCLK = 0;
   localparam int unsigned SY_FS = 1;
   localparam int unsigned SY_DIN = 2;
   localparam int unsigned SY_SEL = 3;
   localparam int unsigned SY_ADH = 4;
   localparam int unsigned SY_ADL = 5;
   localparam int unsigned SY_MS = 6;
   localparam int unsigned SY_W = 7;

   // ****************************************
   // bus register map
   // ****************************************
   localparam logic [7:0] A_ADC1 = 8'h00;
   localparam logic [7:0] A_ADC2 = 8'h04;
   localparam logic [7:0] A_DAC1 = 8'h08;
   localparam logic [7:0] A_DAC2 = 8'h0C;
   localparam logic [7:0] A_STATUS = 8'h10;
   localparam logic [7:0] A_REGSEL = 8'h14;
   localparam logic [7:0] A_REGDATA = 8'h18;
   localparam logic [7:0] A_CMD = 8'h1C;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   typedef struct packed {
      logic [SY_W-1:0] sync1;
      logic [SY_W-1:0] sync2;
      logic bclk_q;
      logic [3:0] div;
      logic gen_bclk;
      logic gen_fs;
      logic [7:0] gpos;
      logic [7:0] pos;
      logic [15:0] rxsh;
      logic [15:0] txsh;
      logic dout;
      logic dout_oe_n;
      logic bclk_oe_n;
      logic [15:0] cmd;
      logic rd_pend;
      logic [7:0] rd_data;
      logic ctl_ok;
      logic [7:0] gap;
      logic [NREGS-1:0][7:0] ctlreg;
      logic [15:0] adc1;
      logic [15:0] adc2;
      logic [15:0] dac1;
      logic [15:0] dac2;
      logic [1:0] adc_vld;
      logic [4:0] regsel;
      logic awrdy;
      logic wrdy;
      logic aw_got;
      logic w_got;
      logic [7:0] awaddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arrdy;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
   } tcsp_state_s;

endpackage

// file: hdl/tcsp_serial_port.sv
// time-slot serial port of a dual voice codec with an axi4-lite register slave
//
// Chosen here: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/1ns
module tcsp_serial_port (
   // clock, reset, enable
   input wire logic clk_in,
   input wire logic srst_in,
   input wire logic ce_in,
   // serial link pins
   input wire logic bclk_in,
   output logic bclk_out,
   output logic bclk_oe_n_out,
   input wire logic frame_sync_line_in,
   output logic frame_sync_line_out,
   output logic frame_sync_line_oe_n_out,
   input wire logic data_in_in,
   output logic data_out_out,
   output logic data_out_oe_n_out,
   // strap pins
   input wire logic ctl_sel_in,
   input wire logic slot_address_high_in,
   input wire logic slot_address_low_in,
   input wire logic master_sel_in,
   // axi4-lite write channels
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   // axi4-lite read channels
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in
);

   tcsp_pkg::tcsp_state_s s_r;
   tcsp_pkg::tcsp_state_s s_nxt;

   logic ms;
   logic bclk_lvl;
   logic fs_lvl;
   logic rise;
   logic fall;
   logic [7:0] pos_new;
   logic [7:0] tpos;
   logic [15:0] rx_word;
   logic [3:0] own1;
   logic [3:0] own2;
   logic ctl_act;

   // ****************************************
   // helpers
   // ****************************************

   // sample word layout from coding and flag settings
   function automatic logic [15:0] fmt_adc(input logic [15:0] smp, input logic [7:0] flag_reg,
                                           input logic [7:0] code_reg, input logic vld);
      logic fl;
      logic [15:0] w;
      fl = flag_reg[tcsp_pkg::FLAG_EN_BIT] & vld;
      w = 16'h0000;
      case (tcsp_pkg::tcsp_coding_e'(code_reg[tcsp_pkg::CODING_HI:tcsp_pkg::CODING_LO]))
         tcsp_pkg::CODE_LIN: begin
            // flag costs the linear lsb, msb moves to bit 14
            if (flag_reg[tcsp_pkg::FLAG_EN_BIT]) begin
               w = {fl, smp[15:1]};
            end else begin
               w = smp;
            end
         end
         tcsp_pkg::CODE_MU, tcsp_pkg::CODE_A: begin
            // software supplies the companded code in the low byte
            w = {fl, 7'h00, smp[7:0]};
         end
         default: w = smp;
      endcase
      return w;
   endfunction

   // command device address against the strap pins
   function automatic logic addr_hit(input logic [15:0] c, input logic adh, input logic adl);
      return (c[tcsp_pkg::CMD_ADH_BIT] == adh) && (c[tcsp_pkg::CMD_ADL_BIT] == adl);
   endfunction

   // ****************************************
   // link decode
   // ****************************************

   // master uses its own generated levels, a slave the synchronised pins
   always_comb begin
      ms = s_r.sync2[tcsp_pkg::SY_MS];
      bclk_lvl = ms ? s_r.gen_bclk : s_r.sync2[tcsp_pkg::SY_BCLK];
      fs_lvl = ms ? s_r.gen_fs : s_r.sync2[tcsp_pkg::SY_FS];
      rise = bclk_lvl & ~s_r.bclk_q;
      fall = ~bclk_lvl & s_r.bclk_q;
      pos_new = fs_lvl ? 8'h00 : 8'(s_r.pos + 8'h01);
      tpos = 8'(s_r.pos + 8'h01);
      rx_word = {s_r.rxsh[14:0], s_r.sync2[tcsp_pkg::SY_DIN]};
      own1 = 4'(tcsp_pkg::SLOT_SAMPLE_BASE
                + {s_r.sync2[tcsp_pkg::SY_ADH], s_r.sync2[tcsp_pkg::SY_ADL], 1'b0});
      own2 = 4'(own1 + 4'h1);
      ctl_act = s_r.ctl_ok & ~s_r.sync2[tcsp_pkg::SY_SEL];
   end

   // ****************************************
   // next state
   // ****************************************

   // one pass computes every field; bus writes come last so their sets win
   always_comb begin
      logic [15:0] word;
      logic [4:0] ridx;
      logic rfit;
      logic [7:0] wa;
      logic hit;
      logic [31:0] rd;
      word = 16'h0000;
      ridx = s_r.cmd[tcsp_pkg::CMD_REG_LO+4:tcsp_pkg::CMD_REG_LO];
      rfit = (s_r.cmd[tcsp_pkg::CMD_REG_HI:tcsp_pkg::CMD_REG_LO+5] == 3'h0);
      wa = 8'h00;
      hit = 1'b0;
      rd = 32'h0000_0000;
      s_nxt = s_r;

      // two-flop synchronisers for every pin
      s_nxt.sync1 = {master_sel_in, slot_address_low_in, slot_address_high_in, ctl_sel_in,
                     data_in_in, frame_sync_line_in, bclk_in};
      s_nxt.sync2 = s_r.sync1;
      s_nxt.bclk_q = bclk_lvl;

      s_nxt.bclk_oe_n = ~ms;
      if (ms) begin
         if (s_r.div == 4'(tcsp_pkg::BCLK_HALF_CYC - 4'h1)) begin
            s_nxt.div = 4'h0;
            s_nxt.gen_bclk = ~s_r.gen_bclk;
            if (!s_r.gen_bclk) begin
               s_nxt.gpos = 8'(s_r.gpos + 8'h01);
               s_nxt.gen_fs = (8'(s_r.gpos + 8'h01) == 8'h00);
            end
         end else begin
            s_nxt.div = 4'(s_r.div + 4'h1);
         end
      end else begin
         s_nxt.div = 4'h0;
         s_nxt.gen_bclk = 1'b0;
         s_nxt.gen_fs = 1'b0;
         s_nxt.gpos = 8'hFF;
      end

      if (fall) begin
         s_nxt.pos = pos_new;
         s_nxt.rxsh = rx_word;
         if (fs_lvl) begin
            if (s_r.gap == 8'h00) begin
               s_nxt.ctl_ok = 1'b1;
               s_nxt.gap = s_r.ctlreg[tcsp_pkg::REG_INTERVAL];
            end else begin
               s_nxt.ctl_ok = 1'b0;
               s_nxt.gap = 8'(s_r.gap - 8'h01);
            end
         end
         // slot ends at its sixteenth bit
         if (pos_new[3:0] == 4'hF) begin
            if (pos_new[7:4] == tcsp_pkg::SLOT_CMD) begin
               s_nxt.cmd = rx_word;
               s_nxt.rd_pend = 1'b0;
               // read request, address match, register number
               if (ctl_act && !rx_word[tcsp_pkg::CMD_RW_BIT]
                   && addr_hit(rx_word, s_r.sync2[tcsp_pkg::SY_ADH],
                               s_r.sync2[tcsp_pkg::SY_ADL])) begin
                  s_nxt.rd_pend = 1'b1;
                  s_nxt.rd_data = 8'h00;
                  if (rx_word[tcsp_pkg::CMD_REG_HI:tcsp_pkg::CMD_REG_LO+5] == 3'h0) begin
                     s_nxt.rd_data = s_r.ctlreg[rx_word[tcsp_pkg::CMD_REG_LO+4:
                                                        tcsp_pkg::CMD_REG_LO]];
                  end
               end
            end else if (pos_new[7:4] == tcsp_pkg::SLOT_DATA) begin
               s_nxt.rd_pend = 1'b0;
               // select pin gates control, data in top byte
               if (ctl_act && s_r.cmd[tcsp_pkg::CMD_RW_BIT] && rfit
                   && addr_hit(s_r.cmd, s_r.sync2[tcsp_pkg::SY_ADH],
                               s_r.sync2[tcsp_pkg::SY_ADL])) begin
                  if (ridx != 5'h00) begin
                     s_nxt.ctlreg[ridx] = rx_word[15:8];
                  end
                  if ((8'(ridx) == tcsp_pkg::REG_INTERVAL) && (rx_word[15:8] != 8'h00)) begin
                     s_nxt.gap = 8'(rx_word[15:8] - 8'h01);
                  end
               end
            end else if (pos_new[7:4] == own1) begin
               s_nxt.dac1 = rx_word;
            end else if (pos_new[7:4] == own2) begin
               s_nxt.dac2 = rx_word;
            end
         end
      end

      // launch on rising edge, msb first
      if (rise) begin
         if (tpos[3:0] == 4'h0) begin
            s_nxt.dout_oe_n = 1'b0;
            if ((tpos[7:4] == tcsp_pkg::SLOT_DATA) && s_r.rd_pend) begin
               word = {s_r.rd_data, 8'h00};
            end else if (tpos[7:4] == own1) begin
               word = fmt_adc(s_r.adc1, s_r.ctlreg[tcsp_pkg::REG_FLAG],
                              s_r.ctlreg[tcsp_pkg::REG_CODING], s_r.adc_vld[0]);
               s_nxt.adc_vld[0] = 1'b0;
            end else if (tpos[7:4] == own2) begin
               word = fmt_adc(s_r.adc2, s_r.ctlreg[tcsp_pkg::REG_FLAG],
                              s_r.ctlreg[tcsp_pkg::REG_CODING], s_r.adc_vld[1]);
               s_nxt.adc_vld[1] = 1'b0;
            end else begin
               // slots not ours are released for other codecs
               s_nxt.dout_oe_n = 1'b1;
            end
            s_nxt.dout = word[15];
            s_nxt.txsh = {word[14:0], 1'b0};
         end else begin
            s_nxt.dout = s_r.txsh[15];
            s_nxt.txsh = {s_r.txsh[14:0], 1'b0};
         end
      end

      // axi write address and data, taken in either order
      if (s_r.awrdy && s_axi_awvalid_in) begin
         s_nxt.aw_got = 1'b1;
         s_nxt.awaddr = s_axi_awaddr_in;
      end
      if (s_r.wrdy && s_axi_wvalid_in) begin
         s_nxt.w_got = 1'b1;
         s_nxt.wdata = s_axi_wdata_in;
         s_nxt.wstrb = s_axi_wstrb_in;
      end
      if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
         wa = {s_r.awaddr[7:2], 2'b00};
         hit = 1'b1;
         case (wa)
            tcsp_pkg::A_ADC1: begin
               if (s_r.wstrb[0]) s_nxt.adc1[7:0] = s_r.wdata[7:0];
               if (s_r.wstrb[1]) s_nxt.adc1[15:8] = s_r.wdata[15:8];
               s_nxt.adc_vld[0] = |s_r.wstrb[1:0];
            end
            tcsp_pkg::A_ADC2: begin
               if (s_r.wstrb[0]) s_nxt.adc2[7:0] = s_r.wdata[7:0];
               if (s_r.wstrb[1]) s_nxt.adc2[15:8] = s_r.wdata[15:8];
               s_nxt.adc_vld[1] = |s_r.wstrb[1:0];
            end
            tcsp_pkg::A_REGSEL: if (s_r.wstrb[0]) s_nxt.regsel = s_r.wdata[4:0];
            tcsp_pkg::A_DAC1, tcsp_pkg::A_DAC2, tcsp_pkg::A_STATUS,
            tcsp_pkg::A_REGDATA, tcsp_pkg::A_CMD: hit = 1'b1;
            default: hit = 1'b0;
         endcase
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = hit ? tcsp_pkg::RESP_OKAY : tcsp_pkg::RESP_SLVERR;
      end
      if (s_r.bvalid && s_axi_bready_in) begin
         s_nxt.bvalid = 1'b0;
         s_nxt.aw_got = 1'b0;
         s_nxt.w_got = 1'b0;
      end
      s_nxt.awrdy = ~s_nxt.aw_got & ~s_nxt.bvalid;
      s_nxt.wrdy = ~s_nxt.w_got & ~s_nxt.bvalid;

      // axi read, answered the cycle after the address is taken
      if (s_r.arrdy && s_axi_arvalid_in) begin
         s_nxt.rresp = tcsp_pkg::RESP_OKAY;
         case ({s_axi_araddr_in[7:2], 2'b00})
            tcsp_pkg::A_ADC1: rd = {16'h0000, s_r.adc1};
            tcsp_pkg::A_ADC2: rd = {16'h0000, s_r.adc2};
            tcsp_pkg::A_DAC1: rd = {16'h0000, s_r.dac1};
            tcsp_pkg::A_DAC2: rd = {16'h0000, s_r.dac2};
            tcsp_pkg::A_STATUS: rd = {16'h0000, s_r.pos, 2'b00, s_r.adc_vld,
                                      1'b0, s_r.rd_pend, ms, s_r.ctl_ok};
            tcsp_pkg::A_REGSEL: rd = {27'h0000000, s_r.regsel};
            tcsp_pkg::A_REGDATA: rd = {24'h000000, s_r.ctlreg[s_r.regsel]};
            tcsp_pkg::A_CMD: rd = {16'h0000, s_r.cmd};
            default: begin
               rd = 32'h0000_0000;
               s_nxt.rresp = tcsp_pkg::RESP_SLVERR;
            end
         endcase
         s_nxt.rdata = rd;
         s_nxt.rvalid = 1'b1;
      end
      if (s_r.rvalid && s_axi_rready_in) begin
         s_nxt.rvalid = 1'b0;
      end
      s_nxt.arrdy = ~s_nxt.rvalid;
   end

   // ****************************************
   // state register
   // ****************************************

   // interval and all control registers clear at reset
   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         s_r <= '0;
         s_r.dout_oe_n <= 1'b1;
         s_r.bclk_oe_n <= 1'b1;
         s_r.gpos <= 8'hFF;
      end else if (ce_in) begin
         s_r <= s_nxt;
      end
   end

   // every output straight from the state register
   assign bclk_out = s_r.gen_bclk;
   assign bclk_oe_n_out = s_r.bclk_oe_n;
   assign frame_sync_line_out = s_r.gen_fs;
   assign frame_sync_line_oe_n_out = s_r.bclk_oe_n;
   assign data_out_out = s_r.dout;
   assign data_out_oe_n_out = s_r.dout_oe_n;
   assign s_axi_awready_out = s_r.awrdy;
   assign s_axi_wready_out = s_r.wrdy;
   assign s_axi_bresp_out = s_r.bresp;
   assign s_axi_bvalid_out = s_r.bvalid;
   assign s_axi_arready_out = s_r.arrdy;
   assign s_axi_rdata_out = s_r.rdata;
   assign s_axi_rresp_out = s_r.rresp;
   assign s_axi_rvalid_out = s_r.rvalid;

   // ****************************************
   // checks
   // ****************************************

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);

   sequence s_frame_start;
      ce_in && fall && fs_lvl;
   endsequence

   property p_frame_restart;
      s_frame_start |=> (s_r.pos == 8'h00);
   endproperty
   a_frame_restart: assert property (p_frame_restart) else $error("slot count not restarted");

   property p_slot_len;
      (ce_in && fall && !fs_lvl) |=> (s_r.pos == 8'($past(s_r.pos) + 8'h01));
   endproperty
   a_slot_len: assert property (p_slot_len) else $error("bit position skipped");

   property p_reg_zero;
      s_r.ctlreg[0] == 8'h00;
   endproperty
   a_reg_zero: assert property (p_reg_zero) else $error("register zero was written");

   property p_interval_reset;
      $fell(srst_in) |-> (s_r.ctlreg[tcsp_pkg::REG_INTERVAL] == 8'h00);
   endproperty
   a_interval_reset: assert property (p_interval_reset) else $error("interval not cleared");

   property p_sel_blocks;
      s_r.sync2[tcsp_pkg::SY_SEL] |=> $stable(s_r.ctlreg);
   endproperty
   a_sel_blocks: assert property (p_sel_blocks) else $error("control taken with select high");

   property p_master_drive;
      (ce_in && ms) ##1 ce_in |=> !bclk_oe_n_out && !frame_sync_line_oe_n_out;
   endproperty
   a_master_drive: assert property (p_master_drive) else $error("master not driving clock");

   property p_launch_rise;
      $changed(data_out_out) |-> $past(rise);
   endproperty
   a_launch_rise: assert property (p_launch_rise) else $error("data changed off rising edge");

   property p_gap_skip;
      (s_frame_start and (s_r.gap != 8'h00)) |=> !s_r.ctl_ok;
   endproperty
   a_gap_skip: assert property (p_gap_skip) else $error("control slot taken inside gap");

   property p_read_only;
      s_r.rd_pend |-> !s_r.cmd[tcsp_pkg::CMD_RW_BIT];
   endproperty
   a_read_only: assert property (p_read_only) else $error("reply armed by write command");

endmodule

// file: tb/tcsp_host_model.sv
// behavioural host serial port that frames traffic toward the codec port
`timescale 1ns/1ns
module tcsp_host_model #(
   parameter int HALF = 6
) (
   // system clock
   input wire logic clk_in,
   // serial pins
   input wire logic dout_in,
   output logic bclk_out,
   output logic fs_out,
   output logic din_out
);
   // ****************************************
   // frame engine
   // ****************************************
   // bit clock stands low between frames
   initial begin
      bclk_out = 1'b0;
      fs_out = 1'b0;
      din_out = 1'b0;
   end
   // one whole frame; sample slots carry a slot-tagged dac word
   task automatic send_frame(input logic [15:0] cmd, input logic [15:0] wd,
         output logic [15:0][15:0] rx);
      logic [15:0] w;
      for (int b = 0; b < 256; b++) begin
         w = (b < 16) ? cmd : (b < 32) ? wd : (16'hC000 | 16'(b / 16));
         @(posedge clk_in);
         bclk_out <= 1'b1;
         fs_out <= (b == 0);
         din_out <= w[15 - (b % 16)];
         repeat (HALF) @(posedge clk_in);
         bclk_out <= 1'b0;
         // reply is long settled by the falling edge
         rx[b / 16][15 - (b % 16)] = dout_in;
         repeat (HALF - 1) @(posedge clk_in);
      end
      // released data line shows the inverse, never a stale level
      @(posedge clk_in);
      din_out <= ~din_out;
   endtask
endmodule

// file: tb/tcsp_serial_port_tb_top.sv
// self-checking bench for the codec time-slot serial port
`timescale 1ns/1ns
module tcsp_serial_port_tb_top;
   // ****************************************
   // signals
   // ****************************************
   logic clk_in = 1'b0, srst_in = 1'b1, ctl_sel = 1'b0, msel = 1'b0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rd;
   logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, rs;
   logic [31:0] rdata;
   logic bclk_o, bclk_oe_n, fs_o, fs_oe_n, dout, dout_oe_n, h_bclk, h_fs, h_din;
   logic [15:0][15:0] rx;
   int bad_count = 0, total_checks = 0, cyc = 0, n, exp5;
   // pins resolve from whoever drives them
   wire bclk_w = bclk_oe_n ? h_bclk : bclk_o;
   wire fs_w = fs_oe_n ? h_fs : fs_o;
   // a released data line shows the inverse of data_out_out, which a released slot holds low
   wire dout_w = dout_oe_n ? ~dout : dout;
   always #10 clk_in = ~clk_in;
   tcsp_serial_port tcsp_serial_port_i (.clk_in(clk_in), .srst_in(srst_in), .ce_in(1'b1),
      .bclk_in(bclk_w), .bclk_out(bclk_o), .bclk_oe_n_out(bclk_oe_n),
      .frame_sync_line_in(fs_w), .frame_sync_line_out(fs_o),
      .frame_sync_line_oe_n_out(fs_oe_n), .data_in_in(h_din), .data_out_out(dout),
      .data_out_oe_n_out(dout_oe_n), .ctl_sel_in(ctl_sel), .slot_address_high_in(1'b0),
      .slot_address_low_in(1'b1), .master_sel_in(msel), .s_axi_awaddr_in(awaddr),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
      .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
      .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready));
   tcsp_host_model tcsp_host_model_i (.clk_in(clk_in), .dout_in(dout_w), .bclk_out(h_bclk),
      .fs_out(h_fs), .din_out(h_din));
   // ****************************************
   // tasks
   // ****************************************
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // ready is looked at mid-cycle, the transfer lands on the next rising edge
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic aw, w, awn, wn;
      aw = 0;
      w = 0;
      @(posedge clk_in);
      awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
      while (!(aw && w)) begin
         @(negedge clk_in);
         awn = awvalid && awready === 1'b1;
         wn = wvalid && wready === 1'b1;
         @(posedge clk_in);
         if (awn) begin awvalid <= 0; aw = 1; end
         if (wn) begin wvalid <= 0; w = 1; end
      end
      do @(negedge clk_in); while (bvalid !== 1'b1);
      r = bresp;
      @(posedge clk_in);
      bready <= 0;
   endtask
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_in);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(negedge clk_in); while (arready !== 1'b1);
      @(posedge clk_in);
      arvalid <= 0;
      do @(negedge clk_in); while (rvalid !== 1'b1);
      d = rdata;
      r = rresp;
      @(posedge clk_in);
      rready <= 0;
   endtask
   // control register seen through the select and data windows
   task automatic rdreg(input logic [4:0] idx, input logic [31:0] exp);
      axw(tcsp_pkg::A_REGSEL, {27'h0, idx}, rs);
      axr(tcsp_pkg::A_REGDATA, rd, rs);
      chk(rd, exp);
   endtask
   task automatic fr(input logic [15:0] cmd, input logic [15:0] wd);
      tcsp_host_model_i.send_frame(cmd, wd, rx);
   endtask
   // hang guard, well above the run length
   always @(posedge clk_in) begin
      cyc <= cyc + 1;
      if (cyc == 95000) begin
         bad_count++;
         print_verdict();
      end
   end
   // ****************************************
   // tests
   // ****************************************
   initial begin
      repeat (3) @(posedge clk_in);
      srst_in <= 1'b0;
      repeat (3) @(posedge clk_in);
      axr(8'h20, rd, rs);
      chk(rs, tcsp_pkg::RESP_SLVERR);
      chk(rd, 32'h0);
      axw(8'h24, 32'h0, rs);
      chk(rs, tcsp_pkg::RESP_SLVERR);
      axw(tcsp_pkg::A_STATUS, 32'hFFFF, rs);
      chk(rs, tcsp_pkg::RESP_OKAY);
      rdreg(5'd17, 32'h0);
      axr(tcsp_pkg::A_REGSEL, rd, rs);
      chk(rd, 32'h11);
      $display("test bus map done");
      fr(16'hA0A0, 16'hAB00);
      rdreg(5'd5, 32'hAB);
      fr(16'h20A0, 16'h0000);
      chk(rx[1], 16'hAB00);
      chk(rx[0], 16'hFFFF);
      chk(rx[2], 16'hFFFF);
      axr(tcsp_pkg::A_CMD, rd, rs);
      chk(rd, 32'h20A0);
      fr(16'hC0A0, 16'h1100);
      rdreg(5'd5, 32'hAB);
      ctl_sel <= 1'b1;
      fr(16'hA0A0, 16'h2200);
      ctl_sel <= 1'b0;
      rdreg(5'd5, 32'hAB);
      fr(16'hA000, 16'h5500);
      rdreg(5'd0, 32'h0);
      $display("test serial control done");
      // linear, mu-law and a-law in turn, flag off
      for (int c = 0; c < 3; c++) begin
         fr(16'hA1E0, {2'(c), 14'h0});
         axw(tcsp_pkg::A_ADC1, 32'h9234, rs);
         axw(tcsp_pkg::A_ADC2, 32'h5678, rs);
         fr(16'h0000, 16'h0000);
         chk(rx[4], (c == 0) ? 16'h9234 : 16'h0034);
         chk(rx[5], (c == 0) ? 16'h5678 : 16'h0078);
      end
      axr(tcsp_pkg::A_DAC1, rd, rs);
      chk(rd, 32'hC004);
      axr(tcsp_pkg::A_DAC2, rd, rs);
      chk(rd, 32'hC005);
      fr(16'hA1A0, 16'h0100);
      axw(tcsp_pkg::A_ADC1, 32'h9234, rs);
      fr(16'h0000, 16'h0000);
      chk(rx[4], 16'h8034);
      chk(rx[5], 16'h0078);
      fr(16'h0000, 16'h0000);
      chk(rx[4], 16'h0034);
      // back to linear with the flag still on
      fr(16'hA1E0, 16'h0000);
      axw(tcsp_pkg::A_ADC1, 32'h9234, rs);
      fr(16'h0000, 16'h0000);
      chk(rx[4], 16'hC91A);
      $display("test sample words done");
      // interval 2: one ignored frame first, then two between valid ones
      fr(16'hA220, 16'h0200);
      exp5 = 32'hAB;
      for (int i = 0; i < 5; i++) begin
         fr(16'hA0A0, {8'(8'h60 + i), 8'h00});
         if (i == 1 || i == 4) exp5 = 32'h60 + i;
         rdreg(5'd5, exp5);
      end
      $display("test control interval done");
      msel <= 1'b1;
      repeat (10) @(posedge clk_in);
      chk(bclk_oe_n, 1'b0);
      chk(fs_oe_n, 1'b0);
      while (fs_o !== 1'b1) @(negedge clk_in);
      n = 0;
      while (bclk_o !== 1'b0) begin @(negedge clk_in); n++; end
      chk(n, tcsp_pkg::BCLK_HALF_CYC);
      while (fs_o !== 1'b0) begin @(negedge clk_in); n++; end
      chk(n, 2 * tcsp_pkg::BCLK_HALF_CYC);
      while (fs_o !== 1'b1) begin @(negedge clk_in); n++; end
      chk(n, 512 * tcsp_pkg::BCLK_HALF_CYC);
      $display("test master timing done");
      print_verdict();
   end
endmodule
